// ---- external_circuit.sv ----
// Outside circuitry on the programmable pins and digital lines.
module external_circuit
(
	input wire logic [17:0] out_i,
	input wire logic [17:0] oe_n_i,
	input wire logic [17:0] drive_i,
	output logic [17:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign level_o = (~oe_n_i & out_i) | (oe_n_i & drive_i);
endmodule

// ---- timing_pins_monitor.sv ----
// Assertion checker bound to the timing-signal pin block.
module timing_pins_monitor
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire timing_pins_pkg::timing_events_t events_i,
	input wire timing_pins_pkg::pin_config_t config_i,
	input wire logic [9:0] pin_out_o,
	input wire logic [9:0] pin_oe_n_o,
	input wire logic scan_conversion_pulse_o,
	input wire logic soft_strobe_out_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic live;
	// An output reflects the previous edge's inputs only if that edge updated the state.
	always_ff @(posedge ref_clk_i) live <= !rst_i && clk_en_i;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i || !live);
	a_scan_pulse: assert property (scan_conversion_pulse_o
		== $past(events_i.conversion & config_i.scan_mode)) else $error("scan pulse");
	a_low_strobes: assert property ({pin_out_o[5], pin_out_o[2]}
		== ~$past({events_i.ao_update, events_i.conversion})) else $error("strobes");
	a_acq_mark: assert property ($rose(events_i.acq_start) |=> $rose(pin_out_o[0])) else $error("acq");
	a_post_mark: assert property (pin_out_o[1]
		== $past(events_i.post_start & config_i.pretrigger)) else $error("post");
	a_start_marks: assert property (pin_out_o[7:6]
		== $past({events_i.scan_start, events_i.wave_start})) else $error("marks");
	a_ctr_mirrors: assert property ({pin_out_o[9:8], pin_out_o[4:3]} == $past({events_i.ctr0_gate,
		events_i.ctr0_source, events_i.ctr1_gate, events_i.ctr1_source})) else $error("mirrors");
	a_soft_strobe: assert property (soft_strobe_out_o == $past(config_i.soft_strobe)) else $error("soft");
	a_pin_enable: assert property ($changed(config_i.pin_out_enable)
		|=> pin_oe_n_o == ~$past(config_i.pin_out_enable)) else $error("enable");
	c_scan: cover property (scan_conversion_pulse_o);
	c_post: cover property (pin_out_o[1]);
	c_drive: cover property (!pin_oe_n_o[0]);
endmodule
bind timing_signal_pin_outputs timing_pins_monitor timing_pins_monitor_i (.*);

// ---- timing_pins_pkg.sv ----
// Shared constants and carrier types for the timing-signal pin block.
package timing_pins_pkg;

	// ************************************************************
	// Pin counts and fixed pin roles
	// ************************************************************
	localparam int PIN_COUNT = 10;
	localparam int SEL_WIDTH = 4;
	localparam int DIO_COUNT = 8;
	localparam int PIN_ACQ_START = 0;
	localparam int PIN_POST_TRIG = 1;
	localparam int PIN_CONVERT = 2;
	localparam int PIN_CTR1_SOURCE = 3;
	localparam int PIN_CTR1_GATE = 4;
	localparam int PIN_UPDATE = 5;
	localparam int PIN_WAVE_START = 6;
	localparam int PIN_SCAN_START = 7;
	localparam int PIN_CTR0_SOURCE = 8;
	localparam int PIN_CTR0_GATE = 9;
	localparam int DIO_CTR0_DIR = 6;
	localparam int DIO_CTR1_DIR = 7;
	localparam int TIMING_INPUTS = 13;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [PIN_COUNT-1:0] PIN_OE_N_RESET = 10'h3ff;
	localparam logic [DIO_COUNT-1:0] DIO_OE_N_RESET = 8'hff;
	localparam logic STROBE_IDLE = 1'b1;

	// Internal events from the acquisition, output and counter sections.
	typedef struct packed {
		logic conversion;
		logic acq_start;
		logic post_start;
		logic ao_update;
		logic wave_start;
		logic scan_start;
		logic ctr0_source;
		logic ctr0_gate;
		logic ctr1_source;
		logic ctr1_gate;
		logic ctr0_out;
		logic ctr1_out;
		logic freq_generator_output;
	} timing_events_t;

	// Software configuration levels.
	typedef struct packed {
		logic scan_mode;
		logic pretrigger;
		logic soft_strobe;
		logic analog_trig_from_pin;
		logic [PIN_COUNT-1:0] pin_out_enable;
		logic [DIO_COUNT-1:0] dio_out_enable;
		logic [DIO_COUNT-1:0] dio_out_value;
	} pin_config_t;

	typedef logic [SEL_WIDTH-1:0] pin_sel_t;

	// Register image of the whole block.
	typedef struct packed {
		logic [PIN_COUNT-1:0] pin_sync1;
		logic [PIN_COUNT-1:0] pin_sync2;
		logic [DIO_COUNT-1:0] dio_sync1;
		logic [DIO_COUNT-1:0] dio_sync2;
		logic [PIN_COUNT-1:0] pin_out;
		logic [PIN_COUNT-1:0] pin_oe_n;
		logic [DIO_COUNT-1:0] dio_out;
		logic [DIO_COUNT-1:0] dio_oe_n;
		logic [TIMING_INPUTS-1:0] timing_in;
		logic analog_trig;
		logic scan_pulse;
		logic strobe;
		logic ctr0_out;
		logic ctr1_out;
		logic freq_generator_output;
		logic ctr0_up;
		logic ctr1_up;
	} pin_state_t;

endpackage

// ---- timing_signal_pin_outputs.sv ----
// Connector-facing routing of timing signals onto programmable and dedicated pins.

// How it works
// - Scan conversion pulse fires once per conversion while scan mode is enabled.
// - Scan conversion pulse rises when the conversion event is seen, input may change.
// - Soft strobe output level follows a software-written level.
// - Pin 0 input feeds the timing selectors or the analog trigger source.
// - Pin 0 acquisition start mark rises when the acquisition sequence begins.
// - In pretrigger mode the acquisition start mark rises as pretrigger conversions begin.
// - Pin 1 post-trigger mark rises at posttrigger start, held low without pretrigger.
// - Pin 2 conversion strobe falls once per conversion.
// - Pins 3 and 8 mirror counter 1 and counter 0 selected sources.
// - Pins 4 and 9 mirror counter 1 and counter 0 selected gates.
// - Dedicated outputs follow counter 1 and counter 0 outputs.
// - Pin 5 update strobe falls once per primary analog output update.
// - Pin 6 waveform start mark rises when waveform generation begins.
// - Pin 7 scan start mark pulses high once at each scan start.
// - Dedicated frequency pin follows the frequency generator output.
// - Digital lines 6 and 7 steer count direction of counters 0 and 1.
// - Any pin may source any timing input; pins can be shared.
// - Each pin has its own software output enable for its designated signal.
// - All eight digital lines float after reset until software sets direction.
module timing_signal_pin_outputs
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire timing_pins_pkg::timing_events_t events_i,
	input wire timing_pins_pkg::pin_config_t config_i,
	input wire timing_pins_pkg::pin_sel_t [timing_pins_pkg::TIMING_INPUTS-1:0] timing_sel_i,
	input wire logic [timing_pins_pkg::PIN_COUNT-1:0] pin_in_i,
	output logic [timing_pins_pkg::PIN_COUNT-1:0] pin_out_o,
	output logic [timing_pins_pkg::PIN_COUNT-1:0] pin_oe_n_o,
	input wire logic [timing_pins_pkg::DIO_COUNT-1:0] dio_in_i,
	output logic [timing_pins_pkg::DIO_COUNT-1:0] dio_out_o,
	output logic [timing_pins_pkg::DIO_COUNT-1:0] dio_oe_n_o,
	output logic [timing_pins_pkg::TIMING_INPUTS-1:0] timing_in_o,
	output logic analog_trig_o,
	output logic scan_conversion_pulse_o,
	output logic soft_strobe_out_o,
	output logic counter0_output_o,
	output logic counter1_output_o,
	output logic freq_generator_output_o,
	output logic counter0_count_up_o,
	output logic counter1_count_up_o
);

	// Whole state of the block, its next value and its value under reset.
	timing_pins_pkg::pin_state_t state;
	timing_pins_pkg::pin_state_t next_state;
	timing_pins_pkg::pin_state_t reset_state;
	logic [timing_pins_pkg::PIN_COUNT-1:0] pin_level;
	logic [timing_pins_pkg::DIO_COUNT-1:0] dio_level;
	logic [timing_pins_pkg::PIN_COUNT-1:0] designated;
	logic [timing_pins_pkg::TIMING_INPUTS-1:0] routed;
	logic post_mark_allowed;
	logic conversion_seen;
	logic update_seen;

	// ************************************************************
	// Synchronised pin views
	// ************************************************************
	// Only the second synchroniser stage is read by logic; the first may still be settling.
	assign pin_level = state.pin_sync2;
	assign dio_level = state.dio_sync2;

	// ************************************************************
	// Event qualifiers
	// ************************************************************
	// The post-trigger mark has no meaning without a pretrigger phase.
	assign post_mark_allowed = config_i.pretrigger;
	// The event pulses come from logic on this clock and need no synchroniser.
	assign conversion_seen = events_i.conversion;
	assign update_seen = events_i.ao_update;

	// ************************************************************
	// Designated internal signal per programmable pin
	// ************************************************************
	// Each pin carries one fixed internal signal; the loop picks it by pin index.
	for (genvar p = 0; p < timing_pins_pkg::PIN_COUNT; p++)
	begin : g_designate
		always_comb
		begin
			designated[p] = 1'b0;
			case (p)
				timing_pins_pkg::PIN_ACQ_START:
				begin
					designated[p] = events_i.acq_start;
				end
				timing_pins_pkg::PIN_POST_TRIG:
				begin
					designated[p] = events_i.post_start & post_mark_allowed;
				end
				// Active-low strobes rest high and drop for the event cycle.
				timing_pins_pkg::PIN_CONVERT:
				begin
					designated[p] = ~conversion_seen;
				end
				// Counter mirrors show the source and gate actually selected.
				timing_pins_pkg::PIN_CTR1_SOURCE:
				begin
					designated[p] = events_i.ctr1_source;
				end
				timing_pins_pkg::PIN_CTR1_GATE:
				begin
					designated[p] = events_i.ctr1_gate;
				end
				timing_pins_pkg::PIN_UPDATE:
				begin
					designated[p] = ~update_seen;
				end
				timing_pins_pkg::PIN_WAVE_START:
				begin
					designated[p] = events_i.wave_start;
				end
				timing_pins_pkg::PIN_SCAN_START:
				begin
					designated[p] = events_i.scan_start;
				end
				timing_pins_pkg::PIN_CTR0_SOURCE:
				begin
					designated[p] = events_i.ctr0_source;
				end
				timing_pins_pkg::PIN_CTR0_GATE:
				begin
					designated[p] = events_i.ctr0_gate;
				end
				default:
				begin
					designated[p] = 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// Input selection: each timing input picks any synchronised pin
	// ************************************************************
	// Codes above the last pin give a steady low rather than an unknown.
	for (genvar g = 0; g < timing_pins_pkg::TIMING_INPUTS; g++)
	begin : g_route
		always_comb
		begin
			routed[g] = 1'b0;
			case (timing_sel_i[g])
				4'h0:
				begin
					routed[g] = pin_level[0];
				end
				4'h1:
				begin
					routed[g] = pin_level[1];
				end
				4'h2:
				begin
					routed[g] = pin_level[2];
				end
				4'h3:
				begin
					routed[g] = pin_level[3];
				end
				4'h4:
				begin
					routed[g] = pin_level[4];
				end
				4'h5:
				begin
					routed[g] = pin_level[5];
				end
				4'h6:
				begin
					routed[g] = pin_level[6];
				end
				4'h7:
				begin
					routed[g] = pin_level[7];
				end
				4'h8:
				begin
					routed[g] = pin_level[8];
				end
				4'h9:
				begin
					routed[g] = pin_level[9];
				end
				default:
				begin
					routed[g] = 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		next_state = state;

		// Two-stage synchronisers on every connector input.
		next_state.pin_sync1 = pin_in_i;
		next_state.pin_sync2 = state.pin_sync1;
		next_state.dio_sync1 = dio_in_i;
		next_state.dio_sync2 = state.dio_sync1;

		// Pin drive values and their active-low enables.
		next_state.pin_out = designated;
		next_state.pin_oe_n = ~config_i.pin_out_enable;
		next_state.dio_out = config_i.dio_out_value;
		next_state.dio_oe_n = ~config_i.dio_out_enable;

		// The analog trigger source sees pin 0 only when software selects it.
		next_state.timing_in = routed;
		next_state.analog_trig = config_i.analog_trig_from_pin
			& pin_level[timing_pins_pkg::PIN_ACQ_START];

		// Dedicated outputs.
		next_state.scan_pulse = config_i.scan_mode & conversion_seen;
		next_state.strobe = config_i.soft_strobe;
		next_state.ctr0_out = events_i.ctr0_out;
		next_state.ctr1_out = events_i.ctr1_out;
		next_state.freq_generator_output = events_i.freq_generator_output;

		// Count direction from digital lines 6 and 7.
		next_state.ctr0_up = dio_level[timing_pins_pkg::DIO_CTR0_DIR];
		next_state.ctr1_up = dio_level[timing_pins_pkg::DIO_CTR1_DIR];
	end

	// ************************************************************
	// Reset image
	// ************************************************************
	// Strobes reset to their idle high level, so that leaving reset
	// shows no false edge on the connector.
	always_comb
	begin
		// Synchronisers start clear.
		reset_state.pin_sync1 = '0;
		reset_state.pin_sync2 = '0;
		reset_state.dio_sync1 = '0;
		reset_state.dio_sync2 = '0;

		// Every pin and digital line is released.
		reset_state.pin_out = '0;
		reset_state.pin_out[timing_pins_pkg::PIN_CONVERT] = timing_pins_pkg::STROBE_IDLE;
		reset_state.pin_out[timing_pins_pkg::PIN_UPDATE] = timing_pins_pkg::STROBE_IDLE;
		reset_state.pin_oe_n = timing_pins_pkg::PIN_OE_N_RESET;
		reset_state.dio_out = '0;
		reset_state.dio_oe_n = timing_pins_pkg::DIO_OE_N_RESET;
		reset_state.timing_in = '0;

		// Dedicated outputs.
		reset_state.analog_trig = 1'b0;
		reset_state.scan_pulse = 1'b0;
		reset_state.strobe = timing_pins_pkg::STROBE_IDLE;
		reset_state.ctr0_out = 1'b0;
		reset_state.ctr1_out = 1'b0;
		reset_state.freq_generator_output = 1'b0;
		reset_state.ctr0_up = 1'b0;
		reset_state.ctr1_up = 1'b0;
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Reset wins over the clock enable, so a frozen block still resets.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state <= reset_state;
		end
		else if (clk_en_i)
		begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Programmable pins.
	assign pin_out_o = state.pin_out;
	assign pin_oe_n_o = state.pin_oe_n;
	// Digital lines.
	assign dio_out_o = state.dio_out;
	assign dio_oe_n_o = state.dio_oe_n;
	// Routed inputs.
	assign timing_in_o = state.timing_in;
	assign analog_trig_o = state.analog_trig;
	// Dedicated outputs.
	assign scan_conversion_pulse_o = state.scan_pulse;
	assign soft_strobe_out_o = state.strobe;
	assign counter0_output_o = state.ctr0_out;
	assign counter1_output_o = state.ctr1_out;
	assign freq_generator_output_o = state.freq_generator_output;
	assign counter0_count_up_o = state.ctr0_up;
	assign counter1_count_up_o = state.ctr1_up;

endmodule

// ---- timing_signal_pin_outputs_tb_top.sv ----
// Self-checking testbench for the timing-signal pin block.
module timing_signal_pin_outputs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1;
	timing_pins_pkg::timing_events_t events_i = '0;
	timing_pins_pkg::pin_config_t config_i = '0;
	timing_pins_pkg::pin_sel_t [12:0] timing_sel_i = '0;
	wire logic [9:0] pin_in_i;
	wire logic [7:0] dio_in_i;
	logic [9:0] pin_out_o, pin_oe_n_o, pin_drive = '0;
	logic [7:0] dio_out_o, dio_oe_n_o, dio_drive = '0;
	logic [12:0] timing_in_o;
	logic analog_trig_o, scan_conversion_pulse_o, soft_strobe_out_o, counter0_output_o, counter1_output_o;
	logic freq_generator_output_o, counter0_count_up_o, counter1_count_up_o;
	int n_fail = 0, n_tests = 0;
	timing_signal_pin_outputs timing_signal_pin_outputs_i (.*);
	external_circuit external_circuit_i (.out_i({pin_out_o, dio_out_o}), .oe_n_i({pin_oe_n_o, dio_oe_n_o}),
		.drive_i({pin_drive, dio_drive}), .level_o({pin_in_i, dio_in_i}));
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, s);
			n_fail++;
		end
	endtask
	task close_out;
		if (n_fail == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task t_events;
		for (int p = 1; p >= 0; p--)
		begin
			@(posedge ref_clk_i);
			config_i <= '{p[0], p[0], p[0], 1'b0, {10{p[0]}} & 10'h155, 8'h00, 8'h00};
			events_i <= 13'h1fff;
			@(posedge ref_clk_i);
			#1;
			chk("pins", p ? 10'h3db : 10'h3d9, pin_out_o);
			chk("outputs", {3'h7, p[0], p[0]}, {counter0_output_o, counter1_output_o,
				freq_generator_output_o, soft_strobe_out_o, scan_conversion_pulse_o});
			chk("enables", p ? 10'h2aa : 10'h3ff, pin_oe_n_o);
		end
	endtask
	task t_freeze;
		@(posedge ref_clk_i);
		clk_en_i <= 1'b0;
		config_i <= '0;
		events_i <= '0;
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("frozen pins", 10'h3d9, pin_out_o);
		@(posedge ref_clk_i);
		clk_en_i <= 1'b1;
		@(posedge ref_clk_i);
		#1;
		chk("released pins", 10'h024, pin_out_o);
	endtask
	task t_pulse;
		@(posedge ref_clk_i);
		config_i.scan_mode <= 1'b1;
		events_i.conversion <= 1'b1;
		events_i.ao_update <= 1'b1;
		@(posedge ref_clk_i);
		events_i.conversion <= 1'b0;
		events_i.ao_update <= 1'b0;
		#1;
		chk("pulse", 3'h1, {pin_out_o[5], pin_out_o[2], scan_conversion_pulse_o});
		@(posedge ref_clk_i);
		#1;
		chk("idle", 3'h6, {pin_out_o[5], pin_out_o[2], scan_conversion_pulse_o});
	endtask
	task t_route;
		for (int p = 0; p < 10; p++)
		begin
			@(posedge ref_clk_i);
			timing_sel_i <= {{12{p[3:0]}}, 4'hf};
			pin_drive <= 10'h001 | (10'h001 << p);
			dio_drive <= {p[1:0], 6'h00};
			config_i.analog_trig_from_pin <= p != 0;
			repeat (3) @(posedge ref_clk_i);
			#1;
			chk("routing", 13'h1ffe, timing_in_o);
			chk("trigger", p != 0, analog_trig_o);
			chk("direction", p[1:0], {counter1_count_up_o, counter0_count_up_o});
		end
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		#1;
		chk("reset", 28'hffffc24, {pin_oe_n_o, dio_oe_n_o, pin_out_o});
		t_events;
		t_freeze;
		t_pulse;
		t_route;
		close_out;
	end
endmodule
